// ---- logic/ahb_regs.sv ----
// Purpose: AHB-Lite slave holding control and status words.
// Assumes: Single word transfers, zero wait states.
// Notes:   Unmapped reads return zero; writes are dropped unless the low address byte equals CTRL_OFS.
`timescale 1ns/1ps
module ahb_regs (
    // System
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    // Bus
    input wire eeprom_pkg::ahb_req_t i_ahb,
    output eeprom_pkg::ahb_rsp_t o_ahb,
    // Block side
    input wire eeprom_pkg::status_t i_status,
    output logic o_enable
);
    import eeprom_pkg::*;

    typedef struct packed {
        logic wr;
        logic [7:0] ofs;
        logic [31:0] ctrl;
        logic [31:0] rdata;
    } regs_t;

    regs_t q;
    regs_t d;
    logic take;
    logic [31:0] stat_word;

    // Status word laid out from the live block state
    always_comb begin
        stat_word = '0;
        stat_word[STAT_BUSY_BIT] = i_status.busy;
        stat_word[STAT_ACT_BIT] = i_status.active;
        stat_word[STAT_ADDR_LSB +: 10] = i_status.addr;
    end

    assign take = i_ahb.hsel && i_ahb.htrans[1] && i_ahb.hready;

    // Address phase latched, write lands in data phase
    always_comb begin
        d = q;
        if (q.wr && q.ofs == CTRL_OFS) begin
            d.ctrl = i_ahb.hwdata;
        end
        d.wr = take && i_ahb.hwrite;
        if (take) begin
            d.ofs = i_ahb.haddr[7:0];
            d.rdata = '0;
            if (!i_ahb.hwrite && i_ahb.haddr[31:8] == 24'h00_0000) begin
                if (i_ahb.haddr[7:0] == CTRL_OFS) begin
                    d.rdata = q.ctrl;
                end else if (i_ahb.haddr[7:0] == STAT_OFS) begin
                    d.rdata = stat_word;
                end
            end
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            q <= '{wr: 1'b0, ofs: 8'h00, ctrl: CTRL_RST, rdata: 32'h0};
        end else begin
            q <= d;
        end
    end

    assign o_ahb = '{hrdata: q.rdata, hreadyout: 1'b1, hresp: 1'b0};
    assign o_enable = q.ctrl[CTRL_EN_BIT];
endmodule

// ---- logic/eeprom_pkg.sv ----
// Purpose: Shared types and constants for the two-wire EEPROM target.
// Assumes: 125 MHz system clock, AHB-Lite register access.
// Notes:   Every figure used by more than one file lives here.
package eeprom_pkg;

    // ----------------------------------------
    // Clock and timing
    // ----------------------------------------
    localparam int unsigned CLK_KHZ = 125000;
    localparam int unsigned WR_TIME_MS = 10;
    // Longest programming time, rounded down to whole cycles
    localparam int unsigned WR_CYCLES_DEF = WR_TIME_MS * CLK_KHZ;
    localparam int unsigned TMR_W = 21;

    // ----------------------------------------
    // Array geometry
    // ----------------------------------------
    localparam int unsigned MEM_BYTES = 1024;
    localparam int unsigned PAGE_SLOTS = 16;
    // Arbitrary device-type code, not tied to any real part
    localparam logic [3:0] TYPE_CODE_DEF = 4'h6;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_DONE = 4'h9;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam int unsigned CTRL_EN_BIT = 0;
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;
    localparam int unsigned STAT_BUSY_BIT = 0;
    localparam int unsigned STAT_ACT_BIT = 1;
    localparam int unsigned STAT_ADDR_LSB = 8;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
        logic hready;
    } ahb_req_t;

    typedef struct packed {
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } ahb_rsp_t;

    typedef struct packed {
        logic busy;
        logic active;
        logic [9:0] addr;
    } status_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_DEV = 3'b001,
        S_WADDR = 3'b010,
        S_WDATA = 3'b011,
        S_RD = 3'b100
    } bus_st_t;

endpackage

// ---- logic/eeprom_target.sv ----
// Purpose: Two-wire bus target front end of a 1k-byte EEPROM.
// Assumes: Serial clock far slower than the system clock.
// Notes:   Pins are oversampled; the data line is open drain.
//
// Chosen here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
// How it works
// - Incoming data bits are sampled on each rising serial clock edge.
// - Driven data line changes only after a falling serial clock edge.
// - Data falling while clock is high marks a start condition.
// - Start is watched always; nothing runs without one.
// - Data rising while clock is high marks a stop, ending a command.
// - Write data reach the array only when a stop follows.
// - Upper four address bits must equal the device-type code.
// - Fifth address bit must equal the device-select pin.
// - Sixth and seventh bits pick one of four 256-byte pages.
// - Last address bit: zero writes, one reads.
// - Array holds 1024 bytes, page bits plus word address.
// - Programming after a stop ends within ten milliseconds.
// - Read address advances after each delivered byte.
// - Acknowledge low after matching address and each written byte.
// - Page write takes sixteen bytes; only low four bits advance.
// - Write-protect high blocks every write.
// - Current read follows last read plus one, or last written.
module eeprom_target #(
    parameter int unsigned WR_CYCLES = eeprom_pkg::WR_CYCLES_DEF,
    parameter logic [3:0] TYPE_CODE = eeprom_pkg::TYPE_CODE_DEF
) (
    // System
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    // Register bus
    input wire eeprom_pkg::ahb_req_t i_ahb,
    output eeprom_pkg::ahb_rsp_t o_ahb,
    // Two-wire bus, data line open drain
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_o,
    output logic o_sda_oe,
    // Strap pins
    input wire logic i_device_select_pin,
    input wire logic i_write_protect
);
    import eeprom_pkg::*;

    // ----------------------------------------
    // Parameter checks
    // ----------------------------------------
    if (WR_CYCLES <= PAGE_SLOTS || WR_CYCLES >= (1 << TMR_W)) begin : g_bad
        $error("WR_CYCLES out of range");
    end

    typedef struct packed {
        bus_st_t st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [9:0] addr;
        logic rw;
        logic first;
        logic nack;
        logic [15:0] mask;
        logic sda_oe;
        logic busy;
        logic [4:0] pidx;
        logic [TMR_W-1:0] tmr;
        logic scl_p;
        logic sda_p;
    } core_t;

    localparam core_t CORE_RST = '{st: S_IDLE, cnt: 4'h0, sh: 8'h00,
        addr: 10'h000, rw: 1'b0, first: 1'b0, nack: 1'b0, mask: 16'h0000,
        sda_oe: 1'b0, busy: 1'b0, pidx: 5'h00, tmr: '0, scl_p: 1'b1,
        sda_p: 1'b1};
    localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(WR_CYCLES - 1);

    core_t q;
    core_t d;
    logic [3:0] pins;
    logic scl_s, sda_s, dsel_s, wp_s;
    logic enable;
    logic scl_rise, scl_fall, start_c, stop_c, match_c;
    logic [7:0] rd_byte;
    logic buf_we, mem_we;
    logic [3:0] buf_idx;
    logic [7:0] mem [MEM_BYTES];
    logic [7:0] page_buf [PAGE_SLOTS];

    // ----------------------------------------
    // Pin synchronisers and register slave
    // ----------------------------------------
    pin_sync #(.W(4), .RST_VAL(4'b0011)) u_sync (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .i_pin({i_write_protect, i_device_select_pin, i_sda, i_scl}),
        .o_sync(pins)
    );
    assign {wp_s, dsel_s, sda_s, scl_s} = pins;

    ahb_regs u_regs (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .i_ahb(i_ahb),
        .o_ahb(o_ahb),
        .i_status('{busy: q.busy, active: q.st != S_IDLE, addr: q.addr}),
        .o_enable(enable)
    );

    // ----------------------------------------
    // Line events
    // ----------------------------------------
    // Start and stop need the clock high on both samples
    assign scl_rise = scl_s && !q.scl_p;
    assign scl_fall = !scl_s && q.scl_p;
    assign start_c = scl_s && q.scl_p && q.sda_p && !sda_s;
    assign stop_c = scl_s && q.scl_p && !q.sda_p && sda_s;
    // Type code, select pin, idle array and software enable
    assign match_c = q.sh[7:4] == TYPE_CODE
        && q.sh[3] == dsel_s
        && !q.busy && enable;
    assign rd_byte = mem[q.addr];

    // ----------------------------------------
    // Protocol and programming engine
    // ----------------------------------------
    always_comb begin
        d = q;
        buf_we = 1'b0;
        buf_idx = q.addr[3:0];
        d.scl_p = scl_s;
        d.sda_p = sda_s;
        // Copy page buffer into array, then hold busy to the bound
        if (q.busy) begin
            d.tmr = q.tmr + 1'b1;
            if (!q.pidx[4]) begin
                d.pidx = q.pidx + 1'b1;
            end
            if (q.tmr == TMR_LAST) begin
                d.busy = 1'b0;
                d.mask = '0;
            end
        end
        if (start_c) begin
            d.st = S_DEV;
            d.cnt = 4'h0;
            d.sda_oe = 1'b0;
        end else if (stop_c) begin
            d.st = S_IDLE;
            d.sda_oe = 1'b0;
            // Pending page commits only on stop and with protect low
            if (q.st == S_WDATA && |q.mask && !wp_s && !q.busy) begin
                d.busy = 1'b1;
                d.tmr = '0;
                d.pidx = 5'h00;
            end
        end else if (scl_rise) begin
            case (q.st)
                S_DEV, S_WADDR, S_WDATA: begin
                    if (q.cnt < BIT_ACK) begin
                        d.sh = {q.sh[6:0], sda_s};
                        d.cnt = q.cnt + 1'b1;
                    end else if (q.cnt == BIT_ACK) begin
                        d.cnt = BIT_DONE;
                    end
                end
                S_RD: begin
                    if (q.cnt < BIT_ACK) begin
                        d.cnt = q.cnt + 1'b1;
                    end else if (q.cnt == BIT_ACK) begin
                        d.nack = sda_s;
                        d.cnt = BIT_DONE;
                    end
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (q.st)
                S_DEV: begin
                    if (q.cnt == BIT_ACK) begin
                        if (match_c) begin
                            d.sda_oe = 1'b1;
                            d.addr[9:8] = q.sh[2:1];
                            d.rw = q.sh[0];
                            if (!q.sh[0]) begin
                                d.mask = '0;
                            end
                        end else begin
                            d.st = S_IDLE;
                        end
                    end else if (q.cnt == BIT_DONE) begin
                        d.cnt = 4'h0;
                        if (q.rw) begin
                            // Current address read, no word address
                            d.st = S_RD;
                            d.sh = rd_byte;
                            d.sda_oe = !rd_byte[7];
                        end else begin
                            d.st = S_WADDR;
                            d.sda_oe = 1'b0;
                        end
                    end
                end
                S_WADDR: begin
                    if (q.cnt == BIT_ACK) begin
                        d.sda_oe = 1'b1;
                        d.addr[7:0] = q.sh;
                        d.first = 1'b1;
                    end else if (q.cnt == BIT_DONE) begin
                        d.sda_oe = 1'b0;
                        d.cnt = 4'h0;
                        d.st = S_WDATA;
                    end
                end
                S_WDATA: begin
                    if (q.cnt == BIT_ACK) begin
                        d.sda_oe = 1'b1;
                        // Address stays on last written byte
                        if (!q.first) begin
                            d.addr[3:0] = q.addr[3:0] + 1'b1;
                        end
                        d.first = 1'b0;
                        buf_idx = d.addr[3:0];
                        buf_we = 1'b1;
                        d.mask[buf_idx] = 1'b1;
                    end else if (q.cnt == BIT_DONE) begin
                        d.sda_oe = 1'b0;
                        d.cnt = 4'h0;
                    end
                end
                S_RD: begin
                    if (q.cnt > 4'h0 && q.cnt < BIT_ACK) begin
                        d.sh = {q.sh[6:0], 1'b0};
                        d.sda_oe = !q.sh[6];
                    end else if (q.cnt == BIT_ACK) begin
                        // Release for the controller's acknowledge
                        d.sda_oe = 1'b0;
                        d.addr = q.addr + 1'b1;
                    end else if (q.cnt == BIT_DONE) begin
                        d.cnt = 4'h0;
                        if (!q.nack) begin
                            d.sh = rd_byte;
                            d.sda_oe = !rd_byte[7];
                        end else begin
                            d.st = S_IDLE;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            q <= CORE_RST;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    // Array has no reset: contents are not volatile state
    assign mem_we = q.busy && !q.pidx[4] && q.mask[q.pidx[3:0]];
    always_ff @(posedge i_clk_sys) begin
        if (mem_we) begin
            mem[{q.addr[9:4], q.pidx[3:0]}] <= page_buf[q.pidx[3:0]];
        end
        if (buf_we) begin
            page_buf[buf_idx] <= q.sh;
        end
    end

    // Open drain: only ever pulls low
    assign o_sda_o = 1'b0;
    assign o_sda_oe = q.sda_oe;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);
    logic line_ev;
    assign line_ev = scl_fall || start_c || stop_c;

    a_bit_sample: assert property (
        q.st == S_DEV && scl_rise && q.cnt < BIT_ACK && !start_c
        |=> q.sh[0] == $past(sda_s))
        else $error("bit not sampled on rising clock");
    a_drive_fall: assert property (
        $changed(q.sda_oe) |-> $past(line_ev))
        else $error("data line changed outside a falling clock");
    a_start_enter: assert property (
        start_c |=> q.st == S_DEV && q.cnt == 4'h0 && !q.sda_oe)
        else $error("start did not restart address reception");
    a_stop_idle: assert property (
        stop_c |=> q.st == S_IDLE ##1 !q.sda_oe)
        else $error("stop did not end the command");
    a_commit_stop: assert property (
        $rose(q.busy) |-> $past(stop_c) && $past(q.st) == S_WDATA)
        else $error("programming began without a stop");
    a_mismatch_off: assert property (
        q.st == S_DEV && scl_fall && q.cnt == BIT_ACK && !match_c
        |=> q.st == S_IDLE && !q.sda_oe)
        else $error("answered a foreign address");
    a_busy_noack: assert property (
        q.busy && q.st == S_DEV && scl_fall && q.cnt == BIT_ACK
        |=> !q.sda_oe)
        else $error("acknowledged while programming");
    a_page_bits: assert property (
        q.st == S_DEV && scl_fall && q.cnt == BIT_ACK && match_c
        |=> q.addr[9:8] == $past(q.sh[2:1]) && q.sda_oe)
        else $error("page bits not taken with acknowledge");
    a_read_step: assert property (
        q.st == S_RD && scl_fall && q.cnt == BIT_ACK && !start_c
        |=> q.addr == $past(q.addr) + 10'h001)
        else $error("read address did not advance");
    a_page_fixed: assert property (
        q.st == S_WDATA && scl_fall && q.cnt == BIT_ACK
        |=> q.addr[9:4] == $past(q.addr[9:4]))
        else $error("page write left its page");
    a_wp_block: assert property (
        stop_c && wp_s && !q.busy |=> !q.busy)
        else $error("write while protected");
    a_prog_bound: assert property (
        q.busy |-> q.tmr <= TMR_LAST)
        else $error("programming exceeded its bound");

    c_commit: cover property ($rose(q.busy));
    c_read_more: cover property (q.st == S_RD && scl_fall
        && q.cnt == BIT_DONE && !q.nack);
    c_read_end: cover property (q.st == S_RD && scl_fall
        && q.cnt == BIT_DONE && q.nack);
endmodule

// ---- logic/pin_sync.sv ----
// Purpose: Two-stage synchroniser for pins from outside the clock domain.
// Assumes: Inputs are slow levels compared with the system clock.
// Notes:   Only the second stage may be read by other logic.
`timescale 1ns/1ps
module pin_sync #(
    parameter int unsigned W = 4,
    parameter logic [W-1:0] RST_VAL = '1
) (
    // System
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    // Pins
    input wire logic [W-1:0] i_pin,
    output logic [W-1:0] o_sync
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_t;

    sync_t q;
    sync_t d;

    // Stage one feeds stage two only
    always_comb begin
        d = q;
        d.s1 = i_pin;
        d.s2 = q.s1;
    end

    // Lines idle high on a pulled-up bus
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            q <= '{s1: RST_VAL, s2: RST_VAL};
        end else begin
            q <= d;
        end
    end

    assign o_sync = q.s2;
endmodule

// ---- tb/eeprom_target_test.sv ----
// Purpose: Self-checking bench for the two-wire EEPROM target.
// Assumes: Short programming time so polling stays cheap.
// Notes:   Array has no reset, so every byte read was written first.
`timescale 1ns/1ps
module eeprom_target_test;
    import eeprom_pkg::*;
    localparam int unsigned WRC = 400;
    localparam logic [3:0] TC = TYPE_CODE_DEF;
    logic clk = 1'b0;
    logic rst = 1'b1;
    ahb_req_t req = '0;
    ahb_req_t bus;
    ahb_rsp_t rsp;
    logic oe, so, scl, pull, line, ack;
    logic dsel = 1'b1;
    logic wp = 1'b0;
    logic [7:0] d;
    logic [31:0] r;
    int n_mismatch = 0;
    int n_checks = 0;

    // Clock and bus glue; open drain line with pull-up
    always #4 clk = ~clk;
    assign line = (oe | pull) ? 1'b0 : 1'b1;
    always_comb begin
        bus = req;
        bus.hready = rsp.hreadyout;
    end

    eeprom_target #(.WR_CYCLES(WRC)) dut (
        .i_clk_sys(clk), .i_sys_rst(rst), .i_ahb(bus), .o_ahb(rsp),
        .i_scl(scl), .i_sda(line), .o_sda_o(so), .o_sda_oe(oe),
        .i_device_select_pin(dsel), .i_write_protect(wp)
    );
    two_wire_ctlr m (.i_line(line), .o_scl(scl), .o_pull(pull));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic results();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask
    // Single AHB-Lite transfer: address phase, then data phase
    task automatic ahb(input logic w, input logic [31:0] a, wd,
                       output logic [31:0] rd);
        int n;
        @(posedge clk);
        req.hsel <= 1'b1;
        req.htrans <= 2'b10;
        req.haddr <= a;
        req.hwrite <= w;
        req.hsize <= 3'b010;
        for (int p = 0; p < 2; p++) begin
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (rsp.hreadyout !== 1'b1 && n < 20);
            if (n >= 20) begin
                n_mismatch++;
                results();
            end
            if (p == 0) begin
                req.hsel <= 1'b0;
                req.htrans <= 2'b00;
                req.hwdata <= wd;
            end
        end
        rd = rsp.hrdata;
        chk("hresp", 32'h0, 32'(rsp.hresp));
    endtask
    task automatic stat();
        ahb(1'b0, {24'h0, STAT_OFS}, '0, r);
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            stat();
            n++;
        end while (r[STAT_BUSY_BIT] !== 1'b0 && n < 300);
        if (n >= 300) begin
            n_mismatch++;
            results();
        end
    endtask
    // Write header: address byte plus word pointer
    task automatic point(input logic [1:0] pg, input logic [7:0] wa);
        m.address({TC, 1'b1, pg, 1'b0}, ack);
        chk("addr ack", 32'h1, 32'(ack));
        m.send(wa, ack);
        chk("word ack", 32'h1, 32'(ack));
    endtask
    // Read header then first byte
    task automatic cur(input logic [1:0] pg, input logic more);
        m.address({TC, 1'b1, pg, 1'b1}, ack);
        chk("read ack", 32'h1, 32'(ack));
        m.recv(more, d);
    endtask
    task automatic put(input logic [7:0] v, input logic [31:0] e);
        m.send(v, ack);
        chk("data ack", e, 32'(ack));
    endtask

    // Drive changes only while the serial clock is low
    always @(oe) begin
        if (!rst) begin
            chk("drive edge", 32'h0, 32'(scl));
        end
    end

    // Overall hang guard
    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        results();
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        // Reset values, unmapped word ignored
        ahb(1'b0, {24'h0, CTRL_OFS}, '0, r);
        chk("ctrl", CTRL_RST, r);
        ahb(1'b1, 32'h8, 32'hffff_ffff, r);
        ahb(1'b0, 32'h8, '0, r);
        chk("unmapped", 32'h0, r);
        stat();
        chk("status", 32'h0, 32'(r[1:0]));
        chk("sda drive", 32'h0, 32'(so));
        // Byte write, busy window refuses polling
        point(2'b10, 8'h35);
        stat();
        chk("active", 32'h2, 32'(r[1:0]));
        chk("ptr w", 32'h235, 32'(r[STAT_ADDR_LSB+:10]));
        put(8'ha5, 32'h1);
        m.stop();
        stat();
        chk("busy", 32'h1, 32'(r[STAT_BUSY_BIT]));
        m.address({TC, 1'b1, 2'b10, 1'b0}, ack);
        chk("poll nack", 32'h0, 32'(ack));
        m.stop();
        wait_idle();
        point(2'b10, 8'h35);
        cur(2'b10, 1'b0);
        chk("rd a5", 32'ha5, 32'(d));
        m.stop();
        // Page write wraps at sixteen bytes
        point(2'b01, 8'h3e);
        put(8'h11, 32'h1);
        put(8'h22, 32'h1);
        put(8'h33, 32'h1);
        m.stop();
        wait_idle();
        cur(2'b01, 1'b0);
        chk("rd wrap", 32'h33, 32'(d));
        m.stop();
        point(2'b01, 8'h3e);
        cur(2'b01, 1'b1);
        chk("rd 3e", 32'h11, 32'(d));
        m.recv(1'b0, d);
        chk("rd 3f", 32'h22, 32'(d));
        m.stop();
        stat();
        chk("ptr", 32'h140, 32'(r[STAT_ADDR_LSB+:10]));
        // Repeated start instead of stop drops the byte
        point(2'b10, 8'h35);
        put(8'h77, 32'h1);
        point(2'b10, 8'h35);
        cur(2'b10, 1'b0);
        chk("no stop", 32'ha5, 32'(d));
        m.stop();
        // Write protect: bytes taken, nothing programmed
        @(posedge clk);
        wp <= 1'b1;
        point(2'b10, 8'h35);
        put(8'h99, 32'h1);
        m.stop();
        stat();
        chk("wp busy", 32'h0, 32'(r[STAT_BUSY_BIT]));
        @(posedge clk);
        wp <= 1'b0;
        point(2'b10, 8'h35);
        cur(2'b10, 1'b0);
        chk("wp data", 32'ha5, 32'(d));
        m.stop();
        // Mismatches leave the line released and the pointer alone
        point(2'b10, 8'h35);
        m.address({TC ^ 4'h3, 1'b1, 2'b00, 1'b1}, ack);
        chk("type nack", 32'h0, 32'(ack));
        m.stop();
        m.address({TC, 1'b0, 2'b00, 1'b1}, ack);
        chk("sel nack", 32'h0, 32'(ack));
        m.stop();
        @(posedge clk);
        dsel <= 1'b0;
        m.address({TC, 1'b0, 2'b10, 1'b1}, ack);
        chk("sel0 ack", 32'h1, 32'(ack));
        m.recv(1'b0, d);
        chk("sel0 data", 32'ha5, 32'(d));
        m.stop();
        @(posedge clk);
        dsel <= 1'b1;
        // Disabled target never acknowledges
        ahb(1'b1, {24'h0, CTRL_OFS}, 32'h0, r);
        m.address({TC, 1'b1, 2'b00, 1'b1}, ack);
        chk("off nack", 32'h0, 32'(ack));
        m.stop();
        ahb(1'b1, {24'h0, CTRL_OFS}, CTRL_RST, r);
        results();
    end
endmodule

// ---- tb/two_wire_ctlr.sv ----
// Purpose: Behavioural two-wire bus controller facing the target.
// Assumes: Data line has a pull-up; o_pull high pulls it low.
// Notes:   Serial clock stands high between frames.
`timescale 1ns/1ps
module two_wire_ctlr (
    // Bus lines
    input wire logic i_line,
    output logic o_scl,
    output logic o_pull
);
    // ----------------------------------------
    // Bit and frame level
    // ----------------------------------------
    // Idle bus: both lines released
    initial begin
        o_scl <= 1'b1;
        o_pull <= 1'b0;
    end
    // Non-blocking drives: a line change landing on a system clock
    // edge is seen only after that edge, so the synchroniser never races
    // One 125 ns clock; data moves mid-low, sampled mid-high
    task automatic bit_io(input logic b, output logic s);
        o_pull <= ~b;
        #31 o_scl <= 1'b1;
        #31 s = i_line;
        #31 o_scl <= 1'b0;
        #32;
    endtask
    // Works from idle and as a repeated start
    task automatic start();
        o_pull <= 1'b0;
        #31 o_scl <= 1'b1;
        #62 o_pull <= 1'b1;
        #62 o_scl <= 1'b0;
        #32;
    endtask
    task automatic stop();
        o_pull <= 1'b1;
        #31 o_scl <= 1'b1;
        #62 o_pull <= 1'b0;
        #62;
    endtask
    // Byte out MSB first; ack true when the target held the line low
    task automatic send(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], s);
        end
        bit_io(1'b1, s);
        ack = ~s;
    endtask
    task automatic recv(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(~ack, s);
    endtask
    // Address byte always follows its start directly
    task automatic address(input logic [7:0] a, output logic ack);
        start();
        send(a, ack);
    endtask
endmodule
